/* File: src/prt_defines.svh */
// constants for the record transfer responder: codes, crc settings, null locator, result values
// assumes inclusion by bare name from the design modules
`ifndef PRT_DEFINES_SVH
`define PRT_DEFINES_SVH
`define PRT_POS_FIRST 8'h00
`define PRT_POS_MIDDLE 8'h01
`define PRT_POS_LAST 8'h04
`define PRT_POS_WHOLE 8'h05
`define PRT_KIND_NEXT 8'h00
`define PRT_KIND_FIRST 8'h01
`define PRT_RC_SUCCESS 8'h00
`define PRT_RC_ERROR 8'h01
`define PRT_RC_BAD_LOCATOR 8'h80
`define PRT_RC_BAD_VERSION 8'h81
`define PRT_RC_UPDATING 8'h83
`define PRT_CRC_POLY 8'h07
`define PRT_CRC_INIT 8'h00
`define PRT_NULL_LOCATOR 32'h0000_0000
`endif

/* File: src/prt_pkg.sv */
// types shared by the record transfer responder
// assumes prt_defines.svh is on the include path
package prt_pkg;
    typedef enum logic [5:0] {
        PRT_IDLE = 6'b000001,
        PRT_CHECK = 6'b000010,
        PRT_HEAD = 6'b000100,
        PRT_DATA = 6'b001000,
        PRT_CRC = 6'b010000,
        PRT_DONE = 6'b100000
    } prt_state_t;
endpackage : prt_pkg

/* File: src/prt_crc8.sv */
// bit-serial crc-8 accumulator, x^8+x^2+x+1, msb of each byte first
// assumes the caller presents one byte per enabled cycle in transfer order
`timescale 1ns/100ps
`include "prt_defines.svh"
module prt_crc8 (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clear,
    input wire logic byte_en,
    input wire logic [7:0] data_byte,
    output logic [7:0] crc
);
    logic [7:0] crc_ff;
    logic [7:0] nxt_crc;

    // fold one byte in eight serial steps, msb first
    function automatic logic [7:0] prt_crc_byte(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (r[7] ^ d[i]) begin
                r = {r[6:0], 1'b0} ^ `PRT_CRC_POLY;
            end else begin
                r = {r[6:0], 1'b0};
            end
        end
        return r;
    endfunction : prt_crc_byte

    // clear has priority so a new read never inherits an old sum
    always_comb begin
        nxt_crc = crc_ff;
        if (clear) begin
            nxt_crc = `PRT_CRC_INIT;
        end else if (byte_en) begin
            nxt_crc = prt_crc_byte(crc_ff, data_byte);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            crc_ff <= `PRT_CRC_INIT;
        end else begin
            crc_ff <= nxt_crc;
        end
    end

    assign crc = crc_ff;
endmodule : prt_crc8

/* File: src/prt_responder.sv */
// record read responder: serves records from a flip-flop repository
// assumes requests arrive as one-cycle pulses with fields held by the requester;
// repository is written over a simple write port by a local updater
//
// Function
// - portion position uses four defined codes
// - zero byte limit gives zero returned count
// - emit exactly returned count record bytes
// - checksum only on last portion responses
// - crc-8 x^8+x^2+x+1 over whole record
// - crc folds bits msb first, transfer order
// - split record beyond capacity or limit
// - locator zero returns first record
// - locator implemented as record table index plus one
// - modification mid read gives new version
// - version mismatch returns error result code
// - only modified records change version tag
// - locked repository answers update in progress
// - updater refreshes stamp and versions on change
// - no following record gives zero locator
// - no remaining portion gives zero locator
`timescale 1ns/100ps
`include "prt_defines.svh"
module prt_responder
    import prt_pkg::*;
#(
    parameter int NUM_RECORDS = 4,
    parameter int RECORD_BYTES = 16,
    parameter int MAX_PORTION = 8
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic req_valid,
    input wire logic [31:0] record_locator,
    input wire logic [31:0] portion_locator,
    input wire logic [7:0] portion_request_kind,
    input wire logic [15:0] requested_byte_limit,
    input wire logic [15:0] record_version_tag,
    input wire logic repo_locked,
    input wire logic wr_en,
    input wire logic [31:0] wr_record,
    input wire logic [31:0] wr_offset,
    input wire logic [7:0] wr_data,
    input wire logic info_req,
    output logic busy,
    output logic head_valid,
    output logic [7:0] result_code,
    output logic [31:0] following_record_locator,
    output logic [31:0] following_portion_locator,
    output logic [7:0] portion_position,
    output logic [15:0] returned_byte_count,
    output logic [15:0] version_out,
    output logic byte_valid,
    output logic [7:0] record_bytes,
    output logic crc_valid,
    output logic [7:0] whole_record_checksum,
    output logic info_valid,
    output logic info_updating,
    output logic [31:0] repo_time_stamp
);
    localparam int IW = $clog2(NUM_RECORDS);
    localparam int OW = $clog2(RECORD_BYTES + 1);
    localparam int AW = $clog2(RECORD_BYTES);
    localparam logic [15:0] CAP = 16'(MAX_PORTION);
    localparam logic [15:0] RLEN = 16'(RECORD_BYTES);

    // repository storage and per-record version tags
    logic [7:0] mem_ff [NUM_RECORDS][RECORD_BYTES];
    logic [15:0] ver_ff [NUM_RECORDS];
    logic [31:0] stamp_ff, nxt_stamp;
    logic [NUM_RECORDS-1:0] nxt_dirty;

    prt_state_t state_ff, nxt_state;
    logic [IW-1:0] rec_ff, nxt_rec;
    logic [OW-1:0] off_ff, nxt_off;
    logic [15:0] left_ff, nxt_left;
    logic clr_crc, fold;
    logic [7:0] crc;
    logic [7:0] cur_byte;

    // response registers
    logic head_valid_ff, nxt_head_valid, busy_ff, nxt_busy;
    logic [7:0] rc_ff, nxt_rc, pos_ff, nxt_pos, byte_ff, nxt_byte;
    logic [31:0] frl_ff, nxt_frl, fpl_ff, nxt_fpl;
    logic [15:0] cnt_ff, nxt_cnt, vout_ff, nxt_vout;
    logic byte_valid_ff, nxt_byte_valid, crc_valid_ff, nxt_crc_valid;
    logic [7:0] chk_ff, nxt_chk;
    logic info_valid_ff, info_upd_ff;

    function automatic logic [15:0] prt_min(input logic [15:0] a, input logic [15:0] b);
        return (a < b) ? a : b;
    endfunction : prt_min

    // locator is a table index plus one so that zero can mean first record
    function automatic logic [31:0] prt_loc(input logic [IW:0] idx);
        return 32'(idx) + 32'h0000_0001;
    endfunction : prt_loc

    // an offset one past the end wraps to byte 0, which is never sent from there
    assign cur_byte = mem_ff[rec_ff][off_ff[AW-1:0]];

    prt_crc8 prt_crc8_inst (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clear(clr_crc),
        .byte_en(fold),
        .data_byte(cur_byte),
        .crc(crc)
    );

    // repository update side: store, version bump only for touched records, stamp
    always_comb begin
        nxt_stamp = stamp_ff;
        nxt_dirty = '0;
        if (wr_en && wr_record < 32'(NUM_RECORDS) && wr_offset < 32'(RECORD_BYTES)) begin
            nxt_dirty[wr_record[IW-1:0]] = 1'b1;
            nxt_stamp = stamp_ff + 32'h0000_0001;
        end
    end

    // versions bump when a write lands, so a read spanning it sees a mismatch
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stamp_ff <= 32'h0000_0000;
            for (int r = 0; r < NUM_RECORDS; r++) begin
                ver_ff[r] <= 16'h0001;
                for (int b = 0; b < RECORD_BYTES; b++) begin
                    mem_ff[r][b] <= 8'h00;
                end
            end
        end else begin
            stamp_ff <= nxt_stamp;
            for (int r = 0; r < NUM_RECORDS; r++) begin
                if (nxt_dirty[r]) begin
                    ver_ff[r] <= ver_ff[r] + 16'h0001;
                end
            end
            if (wr_en && wr_record < 32'(NUM_RECORDS) && wr_offset < 32'(RECORD_BYTES)) begin
                mem_ff[wr_record[IW-1:0]][wr_offset[AW-1:0]] <= wr_data;
            end
        end
    end

    // info query answers with lock status and stamp one cycle later
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            info_valid_ff <= 1'b0;
            info_upd_ff <= 1'b0;
        end else begin
            info_valid_ff <= info_req;
            info_upd_ff <= info_req ? repo_locked : info_upd_ff;
        end
    end

    // request interpreter and response sequencer
    always_comb begin
        logic [15:0] n;
        logic [15:0] remain;
        n = 16'h0000;
        remain = 16'h0000;
        nxt_state = state_ff;
        nxt_rec = rec_ff;
        nxt_off = off_ff;
        nxt_left = left_ff;
        nxt_head_valid = 1'b0;
        nxt_rc = rc_ff;
        nxt_pos = pos_ff;
        nxt_frl = frl_ff;
        nxt_fpl = fpl_ff;
        nxt_cnt = cnt_ff;
        nxt_vout = vout_ff;
        nxt_byte_valid = 1'b0;
        nxt_byte = byte_ff;
        nxt_crc_valid = 1'b0;
        nxt_chk = chk_ff;
        clr_crc = 1'b0;
        fold = 1'b0;
        case (state_ff)
            PRT_IDLE: begin
                if (req_valid) begin
                    nxt_state = PRT_HEAD;
                    nxt_rc = `PRT_RC_SUCCESS;
                    nxt_cnt = 16'h0000;
                    nxt_frl = `PRT_NULL_LOCATOR;
                    nxt_fpl = `PRT_NULL_LOCATOR;
                    nxt_pos = `PRT_POS_WHOLE;
                    // locator zero means first record; else index plus one
                    nxt_rec = (record_locator == `PRT_NULL_LOCATOR) ? '0 :
                              IW'(record_locator - 32'h0000_0001);
                    if (portion_request_kind == `PRT_KIND_FIRST) begin
                        nxt_off = '0; // restart from beginning any time
                        clr_crc = 1'b1;
                    end else begin
                        nxt_off = OW'(portion_locator);
                    end
                    if (repo_locked) begin
                        nxt_rc = `PRT_RC_UPDATING;
                    end else if (record_locator > 32'(NUM_RECORDS)) begin
                        nxt_rc = `PRT_RC_BAD_LOCATOR;
                    end else if (portion_request_kind != `PRT_KIND_FIRST &&
                                 portion_request_kind != `PRT_KIND_NEXT) begin
                        nxt_rc = `PRT_RC_ERROR;
                    end else begin
                        nxt_state = PRT_CHECK;
                    end
                end
            end
            PRT_CHECK: begin
                nxt_state = PRT_HEAD;
                nxt_vout = ver_ff[rec_ff];
                if (portion_request_kind == `PRT_KIND_NEXT &&
                    (record_version_tag != ver_ff[rec_ff] ||
                     off_ff == '0 || 16'(off_ff) >= RLEN)) begin
                    nxt_rc = `PRT_RC_BAD_VERSION;
                end else begin
                    remain = RLEN - 16'(off_ff);
                    n = prt_min(prt_min(remain, CAP), requested_byte_limit);
                    nxt_cnt = n;
                    nxt_left = n;
                    nxt_frl = (32'(rec_ff) + 32'h0000_0001 < 32'(NUM_RECORDS)) ?
                              prt_loc({1'b0, rec_ff} + 1'b1) : `PRT_NULL_LOCATOR;
                    nxt_fpl = (n == remain) ? `PRT_NULL_LOCATOR :
                              32'(off_ff) + 32'(n);
                    if (off_ff == '0) begin
                        nxt_pos = (n == remain) ? `PRT_POS_WHOLE : `PRT_POS_FIRST;
                    end else begin
                        nxt_pos = (n == remain) ? `PRT_POS_LAST : `PRT_POS_MIDDLE;
                    end
                end
            end
            PRT_HEAD: begin
                nxt_head_valid = 1'b1;
                nxt_state = (rc_ff == `PRT_RC_SUCCESS && cnt_ff != 16'h0000) ? PRT_DATA :
                            (rc_ff == `PRT_RC_SUCCESS && pos_ff == `PRT_POS_LAST) ? PRT_CRC :
                            PRT_DONE;
            end
            PRT_DATA: begin
                nxt_byte_valid = 1'b1;
                nxt_byte = cur_byte;
                fold = 1'b1;
                nxt_off = off_ff + OW'(1);
                nxt_left = left_ff - 16'h0001;
                if (left_ff == 16'h0001) begin
                    nxt_state = (pos_ff == `PRT_POS_LAST) ? PRT_CRC : PRT_DONE;
                end
            end
            PRT_CRC: begin
                nxt_crc_valid = 1'b1;
                nxt_chk = crc;
                nxt_state = PRT_DONE;
            end
            PRT_DONE: begin
                nxt_state = PRT_IDLE;
            end
            default: begin
                nxt_state = PRT_IDLE;
            end
        endcase
        nxt_busy = (nxt_state != PRT_IDLE);
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= PRT_IDLE;
            busy_ff <= 1'b0;
            rec_ff <= '0;
            off_ff <= '0;
            left_ff <= 16'h0000;
            head_valid_ff <= 1'b0;
            rc_ff <= `PRT_RC_SUCCESS;
            pos_ff <= `PRT_POS_WHOLE;
            frl_ff <= `PRT_NULL_LOCATOR;
            fpl_ff <= `PRT_NULL_LOCATOR;
            cnt_ff <= 16'h0000;
            vout_ff <= 16'h0000;
            byte_valid_ff <= 1'b0;
            byte_ff <= 8'h00;
            crc_valid_ff <= 1'b0;
            chk_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            busy_ff <= nxt_busy;
            rec_ff <= nxt_rec;
            off_ff <= nxt_off;
            left_ff <= nxt_left;
            head_valid_ff <= nxt_head_valid;
            rc_ff <= nxt_rc;
            pos_ff <= nxt_pos;
            frl_ff <= nxt_frl;
            fpl_ff <= nxt_fpl;
            cnt_ff <= nxt_cnt;
            vout_ff <= nxt_vout;
            byte_valid_ff <= nxt_byte_valid;
            byte_ff <= nxt_byte;
            crc_valid_ff <= nxt_crc_valid;
            chk_ff <= nxt_chk;
        end
    end

    // busy is registered state: high whenever a request is being served
    assign busy = busy_ff;
    assign head_valid = head_valid_ff;
    assign result_code = rc_ff;
    assign following_record_locator = frl_ff;
    assign following_portion_locator = fpl_ff;
    assign portion_position = pos_ff;
    assign returned_byte_count = cnt_ff;
    assign version_out = vout_ff;
    assign byte_valid = byte_valid_ff;
    assign record_bytes = byte_ff;
    assign crc_valid = crc_valid_ff;
    assign whole_record_checksum = chk_ff;
    assign info_valid = info_valid_ff;
    assign info_updating = info_upd_ff;
    assign repo_time_stamp = stamp_ff;
endmodule : prt_responder

/* File: bench/prt_mc_model.sv */
// requester-side monitor: counts bytes of each response, folds a running crc
// assumes clr pulses with every first-portion request
`timescale 1ns/100ps
module prt_mc_model (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clr,
    input wire logic head_valid,
    input wire logic byte_valid,
    input wire logic [7:0] record_bytes,
    output logic [15:0] byte_count,
    output logic [7:0] crc_run
);
    logic [15:0] nxt_cnt_ff;
    logic [7:0] nxt_crc_ff;
    logic [7:0] c;
    // crc restarts per record read, so it spans every portion of one read
    always_comb begin
        nxt_cnt_ff = head_valid ? 16'h0000 : byte_count;
        nxt_crc_ff = crc_run;
        c = crc_run ^ record_bytes;
        if (clr) begin
            nxt_crc_ff = 8'h00;
        end else if (byte_valid) begin
            for (int i = 0; i < 8; i++) begin
                c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
            end
            nxt_crc_ff = c;
            nxt_cnt_ff = nxt_cnt_ff + 16'h0001;
        end
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            byte_count <= 16'h0000;
            crc_run <= 8'h00;
        end else begin
            byte_count <= nxt_cnt_ff;
            crc_run <= nxt_crc_ff;
        end
    end
endmodule : prt_mc_model

/* File: bench/prt_responder_assertions.sv */
// port-level checks of the record responder
// assumes it is bound onto prt_responder, one clock domain
`timescale 1ns/100ps
module prt_responder_assertions (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic req_valid,
    input wire logic [15:0] requested_byte_limit,
    input wire logic repo_locked,
    input wire logic wr_en,
    input wire logic info_req,
    input wire logic busy,
    input wire logic head_valid,
    input wire logic [7:0] result_code,
    input wire logic [7:0] portion_position,
    input wire logic [15:0] returned_byte_count,
    input wire logic byte_valid,
    input wire logic crc_valid,
    input wire logic info_valid,
    input wire logic info_updating,
    input wire logic [31:0] repo_time_stamp
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt_ff;
    // bytes since the last head; lets the count be checked when busy drops
    always_comb begin
        nxt_cnt_ff = head_valid ? 16'h0000 : cnt_ff + {15'h0000, byte_valid};
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= 16'h0000;
        end else begin
            cnt_ff <= nxt_cnt_ff;
        end
    end
    AST_TAKE: assert property (req_valid && !busy |=> busy ##[0:2] head_valid)
        else $error("request not answered in time");
    AST_CODES: assert property (head_valid |->
        portion_position inside {8'h00, 8'h01, 8'h04, 8'h05})
        else $error("undefined portion position");
    AST_ZERO: assert property (head_valid && requested_byte_limit == 16'h0000 |->
        returned_byte_count == 16'h0000)
        else $error("zero limit gave bytes");
    AST_COUNT: assert property ($fell(busy) |-> cnt_ff == returned_byte_count)
        else $error("byte count differs from sent bytes");
    AST_CRCLAST: assert property (crc_valid |->
        portion_position == 8'h04 && !byte_valid)
        else $error("checksum outside last portion");
    AST_LIMIT: assert property (head_valid && result_code == 8'h00 |->
        returned_byte_count <= requested_byte_limit)
        else $error("count above requested limit");
    AST_LOCKED: assert property (repo_locked && req_valid && !busy |->
        ##[1:3] (head_valid && result_code == 8'h83))
        else $error("locked repository not reported");
    AST_INFO: assert property (info_req |=>
        info_valid && info_updating == $past(repo_locked))
        else $error("info answer wrong");
    AST_STAMP: assert property (!wr_en && !$past(wr_en) |=> $stable(repo_time_stamp))
        else $error("stamp moved without a change");
    cover property (head_valid && portion_position == 8'h05);
    cover property (crc_valid);
    cover property (head_valid && result_code == 8'h83);
endmodule : prt_responder_assertions
bind prt_responder prt_responder_assertions prt_responder_assertions_inst (.*);

/* File: bench/prt_responder_test.sv */
// self-checking bench: writes record 0, reads it whole and in portions
// assumes prt_responder with 16-byte records and 16-byte portion capacity
`timescale 1ns/100ps
module prt_responder_test;
    import prt_pkg::*;
    logic ref_clk = 0, resetn = 0, req_valid = 0, repo_locked = 0, wr_en = 0, info_req = 0;
    logic clr = 0;
    logic [7:0] portion_request_kind = 8'h00, wr_data = 8'h00;
    logic [15:0] requested_byte_limit = 16'h0000, record_version_tag = 16'h0000;
    logic [31:0] record_locator = 32'h0, portion_locator = 32'h0, wr_offset = 32'h0;
    logic [31:0] wr_record = 32'h0;
    logic busy, head_valid, byte_valid, crc_valid, info_valid, info_updating;
    logic [7:0] result_code, portion_position, record_bytes, whole_record_checksum, crc_run;
    logic [15:0] returned_byte_count, version_out, byte_count;
    logic [31:0] following_record_locator, following_portion_locator, repo_time_stamp;
    int fails = 0, compares = 0, heads, crcs;
    prt_responder #(.RECORD_BYTES(16), .MAX_PORTION(16)) prt_responder_inst (.*);
    prt_mc_model prt_mc_model_inst (.*);
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    function automatic logic [7:0] pat(input int i);
        return 8'(i * 27) ^ 8'hA5;
    endfunction : pat
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task tick;
        @(posedge ref_clk);
        #2;
    endtask : tick
    task stop_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    // one request; bytes of record 0 are checked as they stream out
    task req(input logic [31:0] loc, off, input logic [7:0] kind, input logic [15:0] lim, ver);
        int n, k;
        n = 0;
        k = 0;
        heads = 0;
        crcs = 0;
        record_locator = loc;
        portion_locator = off;
        portion_request_kind = kind;
        requested_byte_limit = lim;
        record_version_tag = ver;
        clr = (kind == 8'h01);
        req_valid = 1;
        tick;
        req_valid = 0;
        clr = 0;
        do begin
            tick;
            n++;
            heads += head_valid;
            if (byte_valid) begin
                check(record_bytes, pat(off + k));
                k++;
            end
            if (crc_valid) begin
                crcs++;
                check(whole_record_checksum, crc_run);
            end
        end while (busy === 1'b1 && n < 64);
        check(busy, 0);
        check(heads, 1);
    endtask : req
    task hd(input logic [7:0] rc, pos, input logic [15:0] cnt, input logic [31:0] frl, fpl,
            input logic [15:0] ver);
        check(result_code, rc);
        check(portion_position, pos);
        check(returned_byte_count, cnt);
        check(byte_count, cnt);
        check(following_record_locator, frl);
        check(following_portion_locator, fpl);
        check(version_out, ver);
    endtask : hd
    task info(input logic lk, input logic [31:0] st);
        repo_locked = lk;
        tick;
        info_req = 1;
        tick;
        info_req = 0;
        check(info_valid, 1);
        check(info_updating, lk);
        check(repo_time_stamp, st);
    endtask : info
    // watchdog: fires after 5000 cycles; the whole sequence needs well under that
    initial begin
        #100000;
        fails++;
        stop_test;
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        #2 resetn = 1;
        check(busy, 0);
        check(portion_position, 8'h05);
        wr_en = 1;
        for (int i = 0; i < 16; i++) begin
            wr_offset = i;
            wr_data = pat(i);
            tick;
        end
        wr_en = 0;
        info(0, 16);
        $display("fill finished");
        req(0, 0, 8'h01, 16, 0);
        hd(8'h00, 8'h05, 16, 2, 0, 16'h0011);
        check(crcs, 0);
        req(1, 0, 8'h01, 6, 0);
        hd(8'h00, 8'h00, 6, 2, 6, 16'h0011);
        req(1, 6, 8'h00, 6, 16'h0011);
        hd(8'h00, 8'h01, 6, 2, 12, 16'h0011);
        req(1, 12, 8'h00, 6, 16'h0011);
        hd(8'h00, 8'h04, 4, 2, 0, 16'h0011);
        check(crcs, 1);
        req(1, 0, 8'h01, 0, 0);
        check(returned_byte_count, 0);
        $display("transfer finished");
        req(1, 0, 8'h01, 8, 0);
        wr_offset = 0;
        wr_data = pat(0);
        wr_en = 1;
        tick;
        wr_en = 0;
        tick;
        req(1, 8, 8'h00, 8, 16'h0011);
        check(result_code, 8'h81);
        check(returned_byte_count, 0);
        req(1, 0, 8'h01, 16, 0);
        hd(8'h00, 8'h05, 16, 2, 0, 16'h0012);
        info(0, 17);
        $display("update finished");
        req(2, 0, 8'h01, 0, 0);
        check(version_out, 16'h0001);
        check(following_record_locator, 3);
        req(4, 0, 8'h01, 0, 0);
        check(following_record_locator, 0);
        req(5, 0, 8'h01, 0, 0);
        check(result_code, 8'h80);
        req(1, 0, 8'h02, 0, 0);
        check(result_code, 8'h01);
        info(1, 17);
        req(1, 0, 8'h01, 16, 0);
        check(result_code, 8'h83);
        repo_locked = 0;
        $display("errors finished");
        // reconnection: a mid-run reset voids earlier tags and partial reads
        resetn = 0;
        tick;
        resetn = 1;
        check(busy, 0);
        check(repo_time_stamp, 32'h0000_0000);
        req(1, 8, 8'h00, 8, 16'h0012);
        check(result_code, 8'h81);
        req(1, 0, 8'h01, 0, 0);
        check(version_out, 16'h0001);
        $display("reconnect finished");
        stop_test;
    end
endmodule : prt_responder_test
